// [rtl/eccs_pkg.sv]
// eccs_pkg: constants and carrier types for the echo canceller control/status block.
// assumes a single clock domain; register port is the documented serial microport,
// modelled here as a parallel address/data strobe pair already deserialised.
package eccs_pkg;
    // ****************************************************************
    // register map
    // ****************************************************************
    localparam logic [7:0] CHAN_A_CONTROL_ADDR = 8'h00;
    localparam logic [7:0] CHAN_B_CONTROL_ADDR = 8'h20;
    localparam logic [7:0] CHAN_A_CONTROL_RST = 8'h00;
    localparam logic [7:0] CHAN_B_CONTROL_RST = 8'h02;
    // ****************************************************************
    // field positions
    // ****************************************************************
    localparam int SOFT_RESET_BIT = 7;
    localparam int NOISE_INJECT_OFF_BIT = 6;
    localparam int BACK_TO_BACK_SEL_BIT = 5;
    localparam int PAD_BIT = 4;
    localparam int BYPASS_BIT = 3;
    localparam int ADAPT_FREEZE_BIT = 2;
    localparam int EXT_DELAY_BIT = 0;
    // writable mask: channel a keeps bit 1 at 0, channel b keeps bits 1..0 fixed
    localparam logic [7:0] CHAN_A_WMASK = 8'hFD;
    localparam logic [7:0] CHAN_B_WMASK = 8'hFC;
    // status register layout (read-only)
    localparam logic [7:0] STATUS_A_ADDR = 8'h01;
    localparam logic [7:0] STATUS_B_ADDR = 8'h21;

    typedef enum logic [1:0] {
        ECCS_NORMAL,
        ECCS_BACK_TO_BACK,
        ECCS_EXTENDED
    } eccs_config_e;

    // per-channel controls driven to the datapath
    typedef struct packed {
        logic noise_inject_off;
        logic pad_on;
        logic bypass_on;
        logic adapt_freeze;
        logic adapt_run;
    } eccs_chan_ctl_s;

    // per-channel indicators from the canceller core
    typedef struct packed {
        logic gain_down;
        logic converging;
        logic double_talk_flag;
        logic tone_flag;
    } eccs_chan_stat_s;

    typedef struct packed {
        logic [7:0] chan_a_control;
        logic [7:0] chan_b_control;
        logic [7:0] rdata;
        logic rvalid;
        eccs_chan_ctl_s ctl_a;
        eccs_chan_ctl_s ctl_b;
        eccs_config_e cfg;
        eccs_chan_stat_s stat_a;
        eccs_chan_stat_s stat_b;
    } eccs_state_s;
endpackage : eccs_pkg

// [rtl/eccs_top.sv]
// eccs_top: control registers and status indicators of a dual echo canceller.
// assumes deserialised microport accesses (one-cycle strobes) and status inputs
// synchronous to clk_in.
`timescale 1ns/1ps
module eccs_top (
    input wire logic clk_in,                          // 200 MHz clock
    input wire logic rst_n_in,                        // async power-up reset
    input wire logic wr_in,                           // write strobe
    input wire logic rd_in,                           // read strobe
    input wire logic [7:0] addr_in,                   // register address
    input wire logic [7:0] wdata_in,                  // write data
    input wire eccs_pkg::eccs_chan_stat_s stat_a_in,  // channel a indicators
    input wire eccs_pkg::eccs_chan_stat_s stat_b_in,  // channel b indicators
    output logic [7:0] rdata_out,                     // read data
    output logic rvalid_out,                          // read data valid pulse
    output eccs_pkg::eccs_chan_ctl_s ctl_a_out,       // channel a controls
    output eccs_pkg::eccs_chan_ctl_s ctl_b_out,       // channel b controls
    output eccs_pkg::eccs_config_e cfg_out,           // canceller routing
    output eccs_pkg::eccs_chan_stat_s stat_a_out,     // channel a flags
    output eccs_pkg::eccs_chan_stat_s stat_b_out      // channel b flags
);
    // ****************************************************************
    // helpers
    // ****************************************************************
    // per-channel control decode, shared by both channels
    function automatic eccs_pkg::eccs_chan_ctl_s decode_ctl(input logic [7:0] r);
        eccs_pkg::eccs_chan_ctl_s c;
        c.noise_inject_off = r[eccs_pkg::NOISE_INJECT_OFF_BIT];
        c.pad_on = r[eccs_pkg::PAD_BIT];
        c.bypass_on = r[eccs_pkg::BYPASS_BIT];
        c.adapt_freeze = r[eccs_pkg::ADAPT_FREEZE_BIT];
        c.adapt_run = ~r[eccs_pkg::ADAPT_FREEZE_BIT] & ~r[eccs_pkg::BYPASS_BIT];
        return c;
    endfunction : decode_ctl

    // status nibble sits in the low half of the read byte
    function automatic logic [7:0] status_byte(input eccs_pkg::eccs_chan_stat_s s);
        return {4'h0, s};
    endfunction : status_byte

    // host write merged with the fixed reserved bits of one register
    function automatic logic [7:0] merge_write(
        input logic [7:0] wdata,
        input logic [7:0] wmask,
        input logic [7:0] fixed
    );
        return (wdata & wmask) | (fixed & ~wmask);
    endfunction : merge_write

    // extended delay wins if the host breaks the exclusion
    function automatic eccs_pkg::eccs_config_e route_of(input logic [7:0] r);
        eccs_pkg::eccs_config_e c;
        // normal unless a routing bit is set
        c = eccs_pkg::ECCS_NORMAL;
        if (r[eccs_pkg::EXT_DELAY_BIT]) begin
            c = eccs_pkg::ECCS_EXTENDED;
        end else if (r[eccs_pkg::BACK_TO_BACK_SEL_BIT]) begin
            c = eccs_pkg::ECCS_BACK_TO_BACK;
        end
        return c;
    endfunction : route_of

    // unmapped addresses read as zero
    function automatic logic [7:0] read_mux(
        input logic [7:0] addr,
        input eccs_pkg::eccs_state_s s
    );
        logic [7:0] d;
        unique case (addr)
            eccs_pkg::CHAN_A_CONTROL_ADDR: d = s.chan_a_control;
            eccs_pkg::CHAN_B_CONTROL_ADDR: d = s.chan_b_control;
            eccs_pkg::STATUS_A_ADDR: d = status_byte(s.stat_a);
            eccs_pkg::STATUS_B_ADDR: d = status_byte(s.stat_b);
            default: d = 8'h00;
        endcase
        return d;
    endfunction : read_mux

    // ****************************************************************
    // power-up image
    // ****************************************************************
    // values held during and after reset
    localparam eccs_pkg::eccs_state_s RESET_IMAGE = '{
        chan_a_control: eccs_pkg::CHAN_A_CONTROL_RST,
        chan_b_control: eccs_pkg::CHAN_B_CONTROL_RST,
        rdata: 8'h00,
        rvalid: 1'h0,
        ctl_a: '{adapt_run: 1'h1, default: 1'h0},
        ctl_b: '{adapt_run: 1'h1, default: 1'h0},
        cfg: eccs_pkg::ECCS_NORMAL,
        stat_a: '0,
        stat_b: '0
    };

    // ****************************************************************
    // state
    // ****************************************************************
    eccs_pkg::eccs_state_s s_q;
    eccs_pkg::eccs_state_s s_d;
    logic wr_a;
    logic wr_b;

    // ****************************************************************
    // host access decode
    // ****************************************************************
    assign wr_a = wr_in && (addr_in == eccs_pkg::CHAN_A_CONTROL_ADDR);
    assign wr_b = wr_in && (addr_in == eccs_pkg::CHAN_B_CONTROL_ADDR);

    // ****************************************************************
    // next state
    // ****************************************************************
    always_comb begin
        s_d = s_q;
        s_d.rvalid = 1'h0;

        // ************************************************************
        // write path
        // ************************************************************
        // channel a write
        if (wr_a) begin
            s_d.chan_a_control = merge_write(wdata_in, eccs_pkg::CHAN_A_WMASK,
                                             eccs_pkg::CHAN_A_CONTROL_RST);
        end
        if (wr_b) begin
            s_d.chan_b_control = merge_write(wdata_in, eccs_pkg::CHAN_B_WMASK,
                                             eccs_pkg::CHAN_B_CONTROL_RST);
        end

        // ************************************************************
        // soft reset
        // ************************************************************
        // either channel restores both, bit never reads back set
        if (s_d.chan_a_control[eccs_pkg::SOFT_RESET_BIT]
                || s_d.chan_b_control[eccs_pkg::SOFT_RESET_BIT]) begin
            s_d.chan_a_control = eccs_pkg::CHAN_A_CONTROL_RST;
            s_d.chan_b_control = eccs_pkg::CHAN_B_CONTROL_RST;
        end

        // ************************************************************
        // read path
        // ************************************************************
        // a read beside a write returns the value held before it
        if (rd_in) begin
            s_d.rvalid = 1'h1;
            s_d.rdata = read_mux(addr_in, s_q);
        end

        // ************************************************************
        // controls and routing
        // ************************************************************
        // decoded per-channel controls
        s_d.ctl_a = decode_ctl(s_d.chan_a_control);
        s_d.ctl_b = decode_ctl(s_d.chan_b_control);
        s_d.cfg = route_of(s_d.chan_a_control);

        // ************************************************************
        // indicators
        // ************************************************************
        // live indicators
        s_d.stat_a = stat_a_in;
        s_d.stat_b = stat_b_in;
    end

    // ****************************************************************
    // registers
    // ****************************************************************
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            s_q <= RESET_IMAGE;
        end else begin
            s_q <= s_d;
        end
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    // every output is a field of the state register
    assign rdata_out = s_q.rdata;
    assign rvalid_out = s_q.rvalid;
    assign ctl_a_out = s_q.ctl_a;
    assign ctl_b_out = s_q.ctl_b;
    assign cfg_out = s_q.cfg;
    assign stat_a_out = s_q.stat_a;
    assign stat_b_out = s_q.stat_b;
endmodule : eccs_top

// [bench/eccs_host.sv]
// eccs_host: host side of the register port, one access per clock
// assumes acc is called from a process clocked by clk_in
`timescale 1ns/1ps
module eccs_host (
    input wire logic clk_in, // clock
    output logic wr_out, // write strobe
    output logic rd_out, // read strobe
    output logic [7:0] addr_out, // address
    output logic [7:0] wdata_out // write data
);
    initial {wr_out, rd_out, addr_out, wdata_out} = 18'h0;
    // idle cycles scramble the released address and data lines
    task acc(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_in);
        wr_out <= w;
        rd_out <= r;
        addr_out <= (w | r) ? a : ~addr_out;
        wdata_out <= w ? d : ~wdata_out;
    endtask : acc
endmodule : eccs_host

// [bench/eccs_top_asserts.sv]
// eccs_top_asserts: timing and register checks on the eccs_top ports
// assumes one clock and an asynchronous active-low reset
`timescale 1ns/1ps
module eccs_top_asserts (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic wr_in,
    input wire logic rd_in,
    input wire logic [7:0] addr_in,
    input wire logic [7:0] wdata_in,
    input wire eccs_pkg::eccs_chan_stat_s stat_a_in,
    input wire logic [7:0] rdata_out,
    input wire logic rvalid_out,
    input wire eccs_pkg::eccs_chan_ctl_s ctl_a_out,
    input wire eccs_pkg::eccs_config_e cfg_out,
    input wire eccs_pkg::eccs_chan_stat_s stat_a_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    logic wa;
    logic [3:0] wb;
    assign wa = wr_in && addr_in == 8'h00 && !wdata_in[7];
    assign wb = {wdata_in[6], wdata_in[4:2]};
    property p_rv; rd_in |=> rvalid_out; endproperty
    a_rv: assert property (p_rv) else $error("read not answered");
    property p_sa; $past(rst_n_in) |-> stat_a_out == $past(stat_a_in); endproperty
    a_sa: assert property (p_sa) else $error("status flags wrong");
    property p_wr; wa ##1 (rd_in && !wr_in && addr_in == 8'h00)
        |=> rdata_out == ($past(wdata_in, 2) & 8'hFD); endproperty
    a_wr: assert property (p_wr) else $error("read-back wrong");
    property p_bb; wa && wdata_in[5] && !wdata_in[0] |=> cfg_out == 2'h1; endproperty
    a_bb: assert property (p_bb) else $error("back-to-back missed");
    property p_ex; wa && wdata_in[0] |=> cfg_out == 2'h2; endproperty
    a_ex: assert property (p_ex) else $error("extended missed");
    property p_sr; wr_in && wdata_in[7] && (addr_in == 8'h00 || addr_in == 8'h20)
        |=> ctl_a_out == 5'h01 && cfg_out == 2'h0; endproperty
    a_sr: assert property (p_sr) else $error("soft reset missed");
    property p_ct; wa |=> ctl_a_out[4:1] == $past(wb); endproperty
    a_ct: assert property (p_ct) else $error("controls wrong");
    property p_ar; ctl_a_out.adapt_run == !(ctl_a_out.adapt_freeze | ctl_a_out.bypass_on);
    endproperty
    a_ar: assert property (p_ar) else $error("adapt run wrong");
endmodule : eccs_top_asserts
bind eccs_top eccs_top_asserts eccs_top_asserts_inst (.*);

// [bench/eccs_top_tb.sv]
// eccs_top_tb: table-driven register checks, then soft reset, status, reset
// assumes eccs_host drives the register port
`timescale 1ns/1ps
`define CHK(n, e, s) begin n_compared++; if ((s) !== (e)) begin n_fail++; \
    $display("ERROR %s exp %h got %h", n, e, s); end end
module eccs_top_tb;
    logic clk_in = 0;
    logic rst_n_in = 0;
    eccs_pkg::eccs_chan_stat_s sa = '0;
    eccs_pkg::eccs_chan_stat_s sb = '0;
    eccs_pkg::eccs_chan_stat_s st_b;
    eccs_pkg::eccs_chan_ctl_s ctl_b;
    logic wr, rd;
    logic [7:0] ad, wd, rdat;
    eccs_pkg::eccs_config_e cfg;
    int n_fail = 0;
    int n_compared = 0;
    // address, write data, read-back, routing; no ext with back-to-back
    logic [31:0] rows [7] = '{32'h00202001, 32'h20202201, 32'h205C5E01,
        32'h005D5D02, 32'h00020000, 32'h201F1E00, 32'h40550000};
    always #2.5 clk_in = ~clk_in;
    eccs_host eccs_host_inst (.clk_in(clk_in), .wr_out(wr), .rd_out(rd), .addr_out(ad),
        .wdata_out(wd));
    eccs_top eccs_top_inst (.clk_in(clk_in), .rst_n_in(rst_n_in), .wr_in(wr), .rd_in(rd),
        .addr_in(ad), .wdata_in(wd), .stat_a_in(sa), .stat_b_in(sb), .rdata_out(rdat),
        .rvalid_out(), .ctl_a_out(), .ctl_b_out(ctl_b), .cfg_out(cfg), .stat_a_out(),
        .stat_b_out(st_b));
    task wrap_up;
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : wrap_up
    task rd_chk(input logic [7:0] a, input logic [7:0] e);
        eccs_host_inst.acc(0, 1, a, 8'h00);
        eccs_host_inst.acc(0, 0, a, 8'h00);
        @(negedge clk_in);
        `CHK("rdata", e, rdat)
    endtask : rd_chk
    initial begin
        repeat (10) @(posedge clk_in);
        rst_n_in <= 1;
        foreach (rows[i]) begin
            eccs_host_inst.acc(1, 0, rows[i][31:24], rows[i][23:16]);
            rd_chk(rows[i][31:24], rows[i][15:8]);
            `CHK("cfg", rows[i][1:0], cfg)
            $display("row %0d done", i);
        end
        eccs_host_inst.acc(1, 0, 8'h00, 8'h5D);
        eccs_host_inst.acc(1, 0, 8'h20, 8'h80);
        rd_chk(8'h00, 8'h00);
        rd_chk(8'h20, 8'h02);
        `CHK("cfg", 2'h0, cfg)
        `CHK("ctl_b", 5'h01, ctl_b)
        $display("soft reset done");
        @(posedge clk_in) sa <= 4'hB;
        sb <= 4'h6;
        rd_chk(8'h01, 8'h0B);
        rd_chk(8'h21, 8'h06);
        `CHK("stat_b", 4'h6, st_b)
        eccs_host_inst.acc(1, 0, 8'h20, 8'h1C);
        eccs_host_inst.acc(0, 0, 8'h00, 8'h00);
        @(negedge clk_in);
        `CHK("ctl_b", 5'h0E, ctl_b)
        @(posedge clk_in) rst_n_in <= 0;
        @(posedge clk_in) rst_n_in <= 1;
        rd_chk(8'h20, 8'h02);
        `CHK("ctl_b", 5'h01, ctl_b)
        $display("status and reset done");
        wrap_up;
    end
    initial begin
        repeat (400) @(posedge clk_in);
        n_fail++;
        wrap_up;
    end
endmodule : eccs_top_tb
